// file: rtl/rsq_pkg.sv
// package: constants, types and commands of the remote status and queue block
//
// Contract
// [R1] retained header path kept; cleared at power-up, key reset, leading colon, terminator
// [R2] common commands run regardless of the retained path and leave it unchanged
// [R3] 64-byte output queue; overflow flags query error and empties it; also power-up, device clear
// [R4] on gpib a new message with unread queued bytes empties queue, flags query error
// [R5] 256-byte input buffer; full stalls gpib, refuses bytes on serial link
// [R6] master summary bit 6 set when any enabled status byte bit is set
// [R7] enabled status bit rising sets summary, request bit and service request
// [R8] serial poll returns status byte; request bit cleared by that poll
// [R9] status query leaves master summary set; only clear-status clears it
// [R10] status byte: bit5 common, bit4 message waiting, bits1/0 device summaries
// [R11] request mask bit one enables matching status bit, zero masks it
// [R12] status bit 5 set when any masked common event flag is set
// [R13] common event flags cleared by clear-status, their query, power-up
// [R14] common event bit 7 set at power-up or supply recovery; bits 6,1 unused
// [R15] common event bit 5 set on command error
// [R16] common event bit 4 set on execution error
// [R17] common event bit 3 set on device fault
// [R18] common event bit 2 set and queue emptied on query errors
// [R19] gpib only: common event bit 0 set on operation complete
// [R20] status bits 0/1 set when any enabled device event flag is set
// [R21] device event flags cleared by clear-status, own query, power-up
// [R22] measure flags: bit5 fault, bit1 measure end, bit0 conversion end
// [R23] judgement flags: bits5..3 volt, 2..0 resistance, bit6 combined pass
// [R24] device clear clears only message waiting; clear-status clears all but it; code also empties input buffer and retained path on device clear
// [R25] message waiting bit derived from the queue being non-empty
package rsq_pkg;

	localparam int OQ_DEPTH = 64;
	localparam int OQ_AW = 6;
	localparam int IB_DEPTH = 256;
	localparam int IB_AW = 8;
	localparam int PATH_W = 16;

	// status byte bit positions
	localparam int STB_MEAS = 0;
	localparam int STB_JUDGE = 1;
	localparam int STB_MAV = 4;
	localparam int STB_COMMON = 5;
	localparam int STB_MSS = 6;

	// common event bit positions
	localparam int CE_OPC = 0;
	localparam int CE_QYE = 2;
	localparam int CE_DDE = 3;
	localparam int CE_EXE = 4;
	localparam int CE_CME = 5;
	localparam int CE_PON = 7;

	// device event bit positions
	localparam int ME_CONV = 0;
	localparam int ME_END = 1;
	localparam int ME_FAULT = 5;
	localparam int JE_PASS = 6;

	localparam logic [7:0] COMMON_FLAGS_RST = 8'h80;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] JUDGE_USED = 8'h7F;

	typedef enum logic [3:0] {
		RSQ_CMD_NONE = 4'h0,
		RSQ_CMD_WR_SRE = 4'h1,
		RSQ_CMD_WR_ESE = 4'h2,
		RSQ_CMD_WR_ESE0 = 4'h3,
		RSQ_CMD_WR_ESE1 = 4'h4,
		RSQ_CMD_RD_STB = 4'h5,
		RSQ_CMD_RD_SRE = 4'h6,
		RSQ_CMD_RD_ESR = 4'h7,
		RSQ_CMD_RD_ESE = 4'h8,
		RSQ_CMD_RD_MEASURE_EVENT_FLAGS = 4'h9,
		RSQ_CMD_RD_ESE0 = 4'hA,
		RSQ_CMD_RD_JUDGEMENT_EVENT_FLAGS = 4'hB,
		RSQ_CMD_RD_ESE1 = 4'hC,
		RSQ_CMD_CLS = 4'hD,
		RSQ_CMD_DCL = 4'hE
	} rsq_cmd_t;

	typedef struct packed {
		logic power_restored;
		logic cmd_error;
		logic exec_error;
		logic dev_fault;
		logic opc_done;
		logic meas_fault;
		logic meas_end;
		logic conv_end;
		logic [6:0] judge;
	} rsq_events_t;

	typedef struct packed {
		logic key_reset;
		logic colon;
		logic term;
		logic load;
		logic common;
		logic [PATH_W-1:0] value;
	} rsq_path_req_t;

endpackage

// file: rtl/rsq_top.sv
// remote status byte, event registers, output queue and input buffer
`timescale 1ns/1ps
module rsq_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic gpib_select,
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic in_refused,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic msg_start,
	input wire logic [7:0] resp_data,
	input wire logic resp_push,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_read_empty,
	input wire rsq_pkg::rsq_cmd_t cmd,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	input wire logic poll_req,
	output logic [7:0] poll_data,
	output logic poll_valid,
	output logic service_req,
	input wire rsq_pkg::rsq_events_t events,
	input wire rsq_pkg::rsq_path_req_t path_req,
	output logic path_valid,
	output logic [rsq_pkg::PATH_W-1:0] path_value
);

	typedef struct packed {
		logic gpib_s1;
		logic gpib_s2;
		logic [7:0] request_mask;
		logic [7:0] common_event_mask;
		logic [7:0] measure_event_mask;
		logic [7:0] judgement_event_mask;
		logic [7:0] common_event_flags;
		logic [7:0] measure_event_flags;
		logic [7:0] judgement_event_flags;
		logic master_summary_bit;
		logic srq;
		logic sum_prev;
		logic path_valid;
		logic [rsq_pkg::PATH_W-1:0] path;
		logic [rsq_pkg::OQ_AW-1:0] oq_wp;
		logic [rsq_pkg::OQ_AW-1:0] oq_rp;
		logic [rsq_pkg::OQ_AW:0] oq_cnt;
		logic [1:0][7:0] ob_data;
		logic [1:0] ob_valid;
		logic [rsq_pkg::IB_AW-1:0] ib_wp;
		logic [rsq_pkg::IB_AW-1:0] ib_rp;
		logic [rsq_pkg::IB_AW:0] ib_cnt;
		logic [7:0] rx_data;
		logic rx_valid;
		logic in_ready;
		logic in_refused;
		logic [7:0] rdata;
		logic rvalid;
		logic [7:0] poll;
		logic poll_valid;
	} rsq_state_t;

	localparam logic [rsq_pkg::OQ_AW:0] OQ_FULL = (rsq_pkg::OQ_AW+1)'(rsq_pkg::OQ_DEPTH);
	localparam logic [rsq_pkg::IB_AW:0] IB_FULL = (rsq_pkg::IB_AW+1)'(rsq_pkg::IB_DEPTH);

	rsq_state_t s_r;
	rsq_state_t s_nxt;
	logic [7:0] oq_mem [rsq_pkg::OQ_DEPTH];
	logic [7:0] ib_mem [rsq_pkg::IB_DEPTH];
	logic oq_wr;
	logic ib_wr;
	logic gpib;
	logic message_waiting_bit;
	logic [7:0] stb_base;
	logic summary;
	logic rise;
	logic oq_pop;
	logic ib_pop;
	logic overflow;
	logic query_error_flag;
	logic flush;
	logic cls;
	logic dcl;
	logic [7:0] ce_set;
	logic [7:0] me_set;
	logic [7:0] je_set;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.gpib_s1 = gpib_select;
		s_nxt.gpib_s2 = s_r.gpib_s1;
		gpib = s_r.gpib_s2;
		cls = (cmd == rsq_pkg::RSQ_CMD_CLS);
		dcl = (cmd == rsq_pkg::RSQ_CMD_DCL);

		// status byte assembly
		message_waiting_bit = (s_r.oq_cnt != '0) || s_r.ob_valid[0]; // R25
		stb_base = 8'h00;
		stb_base[rsq_pkg::STB_COMMON] = |(s_r.common_event_flags & s_r.common_event_mask); // R12
		stb_base[rsq_pkg::STB_MAV] = message_waiting_bit; // R10
		stb_base[rsq_pkg::STB_JUDGE] = |(s_r.judgement_event_flags & s_r.judgement_event_mask); // R20
		stb_base[rsq_pkg::STB_MEAS] = |(s_r.measure_event_flags & s_r.measure_event_mask); // R20
		summary = |(stb_base & s_r.request_mask); // R11
		rise = summary && !s_r.sum_prev;
		s_nxt.sum_prev = summary;
		s_nxt.master_summary_bit = cls ? 1'b0 : (s_r.master_summary_bit | summary); // R6 R9 R24
		s_nxt.srq = rise | (s_r.srq && !poll_req && !cls); // R7 R8

		// serial poll
		s_nxt.poll_valid = poll_req;
		if (poll_req) begin
			s_nxt.poll = stb_base; // R8
			s_nxt.poll[rsq_pkg::STB_MSS] = s_r.srq;
		end

		// output queue and its two-entry drain buffer
		if (s_r.ob_valid[0] && tx_ready) begin
			s_nxt.ob_data[0] = s_r.ob_data[1];
			s_nxt.ob_valid = {1'b0, s_r.ob_valid[1]};
		end
		oq_pop = (s_r.oq_cnt != '0) && !s_nxt.ob_valid[1];
		if (oq_pop) begin
			if (!s_nxt.ob_valid[0]) begin
				s_nxt.ob_data[0] = oq_mem[s_r.oq_rp];
				s_nxt.ob_valid[0] = 1'b1;
			end else begin
				s_nxt.ob_data[1] = oq_mem[s_r.oq_rp];
				s_nxt.ob_valid[1] = 1'b1;
			end
			s_nxt.oq_rp = s_r.oq_rp + 1'b1;
		end
		overflow = resp_push && (s_r.oq_cnt == OQ_FULL) && !oq_pop; // R3
		oq_wr = resp_push && !overflow;
		if (oq_wr) begin
			s_nxt.oq_wp = s_r.oq_wp + 1'b1;
		end
		s_nxt.oq_cnt = s_r.oq_cnt + (rsq_pkg::OQ_AW+1)'(oq_wr) - (rsq_pkg::OQ_AW+1)'(oq_pop);
		query_error_flag = overflow || (gpib && msg_start && message_waiting_bit) || (gpib && tx_read_empty); // R4 R18
		flush = query_error_flag || dcl; // R3 R24
		if (flush) begin
			s_nxt.oq_wp = '0;
			s_nxt.oq_rp = '0;
			s_nxt.oq_cnt = '0;
			s_nxt.ob_valid = 2'b00;
		end

		// input buffer
		ib_wr = in_valid && s_r.in_ready;
		s_nxt.in_refused = in_valid && !s_r.in_ready && !gpib; // R5
		if (s_r.rx_valid && rx_ready) begin
			s_nxt.rx_valid = 1'b0;
		end
		ib_pop = (s_r.ib_cnt != '0) && !s_nxt.rx_valid;
		if (ib_pop) begin
			s_nxt.rx_data = ib_mem[s_r.ib_rp];
			s_nxt.rx_valid = 1'b1;
			s_nxt.ib_rp = s_r.ib_rp + 1'b1;
		end
		if (ib_wr) begin
			s_nxt.ib_wp = s_r.ib_wp + 1'b1;
		end
		s_nxt.ib_cnt = s_r.ib_cnt + (rsq_pkg::IB_AW+1)'(ib_wr) - (rsq_pkg::IB_AW+1)'(ib_pop);
		if (dcl) begin
			s_nxt.ib_wp = '0;
			s_nxt.ib_rp = '0;
			s_nxt.ib_cnt = '0;
			s_nxt.rx_valid = 1'b0;
		end
		s_nxt.in_ready = (s_nxt.ib_cnt != IB_FULL); // R5

		// retained header path
		if (path_req.key_reset || path_req.colon || path_req.term || dcl) begin
			s_nxt.path_valid = 1'b0; // R1
		end else if (path_req.load && !path_req.common) begin
			s_nxt.path_valid = 1'b1; // R2
			s_nxt.path = path_req.value;
		end

		// event sources
		ce_set = 8'h00;
		ce_set[rsq_pkg::CE_PON] = events.power_restored; // R14
		ce_set[rsq_pkg::CE_CME] = events.cmd_error; // R15
		ce_set[rsq_pkg::CE_EXE] = events.exec_error; // R16
		ce_set[rsq_pkg::CE_DDE] = events.dev_fault; // R17
		ce_set[rsq_pkg::CE_QYE] = query_error_flag; // R18
		ce_set[rsq_pkg::CE_OPC] = events.opc_done && gpib; // R19
		me_set = 8'h00;
		me_set[rsq_pkg::ME_FAULT] = events.meas_fault; // R22
		me_set[rsq_pkg::ME_END] = events.meas_end;
		me_set[rsq_pkg::ME_CONV] = events.conv_end;
		je_set = {1'b0, events.judge} & rsq_pkg::JUDGE_USED; // R23

		// command port: reads answer next cycle, flag reads clear
		s_nxt.rvalid = 1'b0;
		case (cmd)
			rsq_pkg::RSQ_CMD_WR_SRE: s_nxt.request_mask = cmd_wdata; // R11
			rsq_pkg::RSQ_CMD_WR_ESE: s_nxt.common_event_mask = cmd_wdata;
			rsq_pkg::RSQ_CMD_WR_ESE0: s_nxt.measure_event_mask = cmd_wdata;
			rsq_pkg::RSQ_CMD_WR_ESE1: s_nxt.judgement_event_mask = cmd_wdata;
			rsq_pkg::RSQ_CMD_RD_STB: begin
				s_nxt.rdata = stb_base;
				s_nxt.rdata[rsq_pkg::STB_MSS] = s_r.master_summary_bit; // R9
				s_nxt.rvalid = 1'b1;
			end
			rsq_pkg::RSQ_CMD_RD_SRE: begin
				s_nxt.rdata = s_r.request_mask;
				s_nxt.rvalid = 1'b1;
			end
			rsq_pkg::RSQ_CMD_RD_ESR: begin
				s_nxt.rdata = s_r.common_event_flags;
				s_nxt.rvalid = 1'b1;
				s_nxt.common_event_flags = 8'h00; // R13
			end
			rsq_pkg::RSQ_CMD_RD_ESE: begin
				s_nxt.rdata = s_r.common_event_mask;
				s_nxt.rvalid = 1'b1;
			end
			rsq_pkg::RSQ_CMD_RD_MEASURE_EVENT_FLAGS: begin
				s_nxt.rdata = s_r.measure_event_flags;
				s_nxt.rvalid = 1'b1;
				s_nxt.measure_event_flags = 8'h00; // R21
			end
			rsq_pkg::RSQ_CMD_RD_ESE0: begin
				s_nxt.rdata = s_r.measure_event_mask;
				s_nxt.rvalid = 1'b1;
			end
			rsq_pkg::RSQ_CMD_RD_JUDGEMENT_EVENT_FLAGS: begin
				s_nxt.rdata = s_r.judgement_event_flags;
				s_nxt.rvalid = 1'b1;
				s_nxt.judgement_event_flags = 8'h00; // R21
			end
			rsq_pkg::RSQ_CMD_RD_ESE1: begin
				s_nxt.rdata = s_r.judgement_event_mask;
				s_nxt.rvalid = 1'b1;
			end
			rsq_pkg::RSQ_CMD_CLS: begin
				s_nxt.common_event_flags = 8'h00; // R13
				s_nxt.measure_event_flags = 8'h00; // R21
				s_nxt.judgement_event_flags = 8'h00;
			end
			default: begin
			end
		endcase

		// a set arriving with a clear wins
		s_nxt.common_event_flags = s_nxt.common_event_flags | ce_set;
		s_nxt.measure_event_flags = s_nxt.measure_event_flags | me_set;
		s_nxt.judgement_event_flags = s_nxt.judgement_event_flags | je_set;
	end

	////////////////////////////////////////////////////////////////////////
	// registers and memories

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.common_event_flags <= rsq_pkg::COMMON_FLAGS_RST; // R14
			s_r.request_mask <= rsq_pkg::MASK_RST;
			s_r.common_event_mask <= rsq_pkg::MASK_RST;
			s_r.measure_event_mask <= rsq_pkg::MASK_RST;
			s_r.judgement_event_mask <= rsq_pkg::MASK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (oq_wr) begin
			oq_mem[s_r.oq_wp] <= resp_data;
		end
		if (ib_wr) begin
			ib_mem[s_r.ib_wp] <= in_data;
		end
	end

	assign in_ready = s_r.in_ready;
	assign in_refused = s_r.in_refused;
	assign rx_data = s_r.rx_data;
	assign rx_valid = s_r.rx_valid;
	assign tx_data = s_r.ob_data[0];
	assign tx_valid = s_r.ob_valid[0];
	assign cmd_rdata = s_r.rdata;
	assign cmd_rvalid = s_r.rvalid;
	assign poll_data = s_r.poll;
	assign poll_valid = s_r.poll_valid;
	assign service_req = s_r.srq;
	assign path_valid = s_r.path_valid;
	assign path_value = s_r.path;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_path_colon_clear: assert property (path_req.colon |=> !path_valid) // R1
		else $error("path kept after leading colon");
	chk_common_keeps_path: assert property (path_req.common && !path_req.colon && !path_req.term
		&& !path_req.key_reset && !dcl |=> $stable(path_value) && $stable(path_valid)) // R2
		else $error("common command changed path");
	chk_overflow_empties: assert property (overflow |=> s_r.oq_cnt == '0 && !tx_valid
		&& s_r.common_event_flags[rsq_pkg::CE_QYE]) // R3
		else $error("overflow did not empty queue");
	chk_gpib_msg_flush: assert property (gpib && msg_start && message_waiting_bit && !dcl |=> !tx_valid
		&& s_r.common_event_flags[rsq_pkg::CE_QYE]) // R4
		else $error("new message did not flush queue");
	chk_ib_full_stall: assert property (s_r.ib_cnt == IB_FULL |-> !in_ready) // R5
		else $error("ready while input buffer full");
	chk_srq_on_rise: assert property (rise && !cls |=> service_req ##0 s_r.master_summary_bit) // R7
		else $error("no service request on rising summary");
	chk_poll_clears_req: assert property (poll_req && !rise |=> !service_req
		&& poll_valid && poll_data[rsq_pkg::STB_MSS] == $past(service_req)) // R8
		else $error("poll answer or clear wrong");
	chk_mss_sticky: assert property (s_r.master_summary_bit && !cls |=> s_r.master_summary_bit) // R9
		else $error("summary dropped without clear status");
	chk_stb_layout: assert property (cmd == rsq_pkg::RSQ_CMD_RD_STB |=> cmd_rvalid
		&& cmd_rdata[7] == 1'b0 && cmd_rdata[3:2] == 2'b00 && cmd_rdata[4] == $past(message_waiting_bit)) // R10
		else $error("status byte layout wrong");
	chk_esr_read_clear: assert property (cmd == rsq_pkg::RSQ_CMD_RD_ESR && ce_set == 8'h00
		|=> s_r.common_event_flags == 8'h00) // R13
		else $error("common flags not cleared by read");
	chk_judge_unused: assert property (s_r.judgement_event_flags[7] == 1'b0
		&& s_r.measure_event_flags[7:6] == 2'b00) // R23
		else $error("unused event bit set");
	chk_mav_follows: assert property (dcl |=> !message_waiting_bit) // R24
		else $error("device clear left message waiting");

	// event flag sources, clears and the poll answer
	chk_pon_sets: assert property (events.power_restored |=> s_r.common_event_flags[rsq_pkg::CE_PON]) // R14
		else $error("power flag not set");
	chk_cme_sets: assert property (events.cmd_error |=> s_r.common_event_flags[rsq_pkg::CE_CME]) // R15
		else $error("command error flag not set");
	chk_exe_sets: assert property (events.exec_error |=> s_r.common_event_flags[rsq_pkg::CE_EXE]) // R16
		else $error("run failure flag not set");
	chk_dde_sets: assert property (events.dev_fault |=> s_r.common_event_flags[rsq_pkg::CE_DDE]) // R17
		else $error("device fault flag not set");
	chk_qye_sets: assert property (query_error_flag |=> s_r.common_event_flags[rsq_pkg::CE_QYE]
		&& s_r.oq_cnt == '0 && !tx_valid) // R18
		else $error("query error not flagged or queue kept");
	chk_opc_gpib: assert property (events.opc_done && gpib |=> s_r.common_event_flags[rsq_pkg::CE_OPC]) // R19
		else $error("completion flag missing");
	chk_opc_serial: assert property (events.opc_done && !gpib && !s_r.common_event_flags[rsq_pkg::CE_OPC]
		|=> !s_r.common_event_flags[rsq_pkg::CE_OPC]) // R19
		else $error("completion flag set on serial link");
	chk_meas_sets: assert property (events.meas_fault |=> s_r.measure_event_flags[rsq_pkg::ME_FAULT]) // R22
		else $error("measure fault flag not set");
	chk_judge_pass: assert property (events.judge[rsq_pkg::JE_PASS]
		|=> s_r.judgement_event_flags[rsq_pkg::JE_PASS]) // R23
		else $error("combined pass flag not set");
	chk_cls_clears: assert property (cls && events == '0 && !query_error_flag |=> s_r.common_event_flags == 8'h00
		&& s_r.measure_event_flags == 8'h00 && s_r.judgement_event_flags == 8'h00 && !s_r.master_summary_bit) // R21
		else $error("clear status left flags");
	chk_measure_event_flags_read_clear: assert property (cmd == rsq_pkg::RSQ_CMD_RD_MEASURE_EVENT_FLAGS && me_set == 8'h00
		|=> s_r.measure_event_flags == 8'h00) // R21
		else $error("measure flags not cleared by read");
	chk_mss_from_summary: assert property (summary && !cls |=> s_r.master_summary_bit) // R6
		else $error("summary not reflected in master bit");
	chk_mask_blocks: assert property (s_r.request_mask == 8'h00 |-> !summary) // R11
		else $error("masked bits reached summary");
	chk_serial_refuse: assert property (in_valid && !in_ready && !gpib |=> in_refused) // R5
		else $error("serial byte beyond capacity not refused");
	chk_poll_layout: assert property (poll_req |=> poll_data[7] == 1'b0 && poll_data[3:2] == 2'b00
		&& poll_data[4] == $past(message_waiting_bit)) // R10
		else $error("poll byte layout wrong");

	cov_service_request: cover property (rise ##[1:20] poll_req);
	cov_oq_overflow: cover property (overflow);
	cov_ib_full: cover property (s_r.ib_cnt == IB_FULL ##1 in_valid);
	cov_path_reuse: cover property (path_req.load ##1 path_req.common ##1 path_valid);
	cov_serial_refuse: cover property (in_refused);

endmodule

// file: sim/remote_status_and_queues_bench.sv
// self-checking bench of the remote status and queue block
`timescale 1ns/1ps
module remote_status_and_queues_bench;
	logic clk, reset_n, gpib_select, in_valid, in_ready, in_refused, rx_valid, rx_ready, msg_start;
	logic resp_push, tx_valid, tx_ready, tx_read_empty, cmd_rvalid, poll_req, poll_valid;
	logic service_req, path_valid, stall, rx_en;
	logic [7:0] in_data, rx_data, resp_data, tx_data, cmd_wdata, cmd_rdata, poll_data, rd, v;
	logic [15:0] path_value, w;
	rsq_pkg::rsq_cmd_t cmd;
	rsq_pkg::rsq_events_t events;
	rsq_pkg::rsq_path_req_t path_req;
	int bad_count, n_tests, acc, rx_idx, refused, i;
	int ceb[5] = '{rsq_pkg::CE_PON, rsq_pkg::CE_CME, rsq_pkg::CE_EXE, rsq_pkg::CE_DDE, rsq_pkg::CE_OPC};
	logic [7:0] mval[4] = '{8'h00, 8'h00, 8'h01, 8'h40};
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];

	rsq_top dut_u (.clk, .reset_n, .gpib_select, .in_data, .in_valid, .in_ready, .in_refused,
		.rx_data, .rx_valid, .rx_ready, .msg_start, .resp_data, .resp_push, .tx_data, .tx_valid,
		.tx_ready, .tx_read_empty, .cmd, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .poll_req,
		.poll_data, .poll_valid, .service_req, .events, .path_req, .path_valid, .path_value);
	rsq_ctrl_model ctrl_u (.clk, .reset_n, .stall, .tx_ready);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#400000;
		bad_count++;
		final_report();
	end

	// monitors and the input byte source
	always @(posedge clk) begin
		if (tx_valid && tx_ready) got_q.push_back(tx_data);
		if (in_valid && in_ready) begin
			acc <= acc + 1;
			in_data <= in_data + 8'h01;
		end
		if (in_refused) refused <= refused + 1;
		if (rx_valid && rx_ready) begin
			check("rx_order", rx_data, rx_idx[7:0]);
			rx_idx <= rx_idx + 1;
		end
		rx_ready <= rx_en & 1'($urandom_range(1));
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask

	function automatic rsq_pkg::rsq_cmd_t cc(input int n);
		return rsq_pkg::rsq_cmd_t'(n[3:0]);
	endfunction

	task automatic cw(input rsq_pkg::rsq_cmd_t c, input logic [7:0] d);
		@(posedge clk);
		cmd <= c;
		cmd_wdata <= d;
		@(posedge clk);
		cmd <= rsq_pkg::RSQ_CMD_NONE;
		#1;
		rd = cmd_rdata;
	endtask

	task automatic rchk(input rsq_pkg::rsq_cmd_t c, input logic [7:0] e, input string nm);
		cw(c, 8'h00);
		check(nm, {cmd_rvalid, rd}, {1'b1, e});
	endtask

	task automatic ev(input logic [14:0] e);
		@(posedge clk);
		events <= e;
		@(posedge clk);
		events <= '0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// 0 new message, 1 empty read, 2 serial poll
	task automatic pl(input int s);
		@(posedge clk);
		msg_start <= (s == 0);
		tx_read_empty <= (s == 1);
		poll_req <= (s == 2);
		@(posedge clk);
		{msg_start, tx_read_empty, poll_req} <= 3'b000;
		#1;
	endtask

	task automatic pth(input logic [20:0] p);
		@(posedge clk);
		path_req <= p;
		@(posedge clk);
		path_req <= '0;
		#1;
	endtask

	task automatic push_n(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			v = 8'($urandom);
			resp_push <= 1'b1;
			resp_data <= v;
			exp_q.push_back(v);
		end
		@(posedge clk);
		resp_push <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, in_valid, rx_en, msg_start, resp_push, tx_read_empty, poll_req} = '0;
		{in_data, resp_data, cmd_wdata} = '0;
		{bad_count, n_tests, acc, rx_idx, refused} = '0;
		gpib_select = 1'b1;
		stall = 1'b1;
		cmd = rsq_pkg::RSQ_CMD_NONE;
		events = '0;
		path_req = '0;
		v = 8'($urandom(32'hbb133911));
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		check("srq_reset", service_req, 1'b0);
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, rsq_pkg::COMMON_FLAGS_RST, "power_flag");
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h00, "esr_read_clear");
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h00, "stb_reset");
		for (i = 0; i < 4; i++) begin
			rchk(cc(6 + 2 * i), rsq_pkg::MASK_RST, "mask_reset");
			v = 8'($urandom);
			cw(cc(1 + i), v);
			rchk(cc(6 + 2 * i), v, "mask_rw");
			cw(cc(1 + i), mval[i]);
		end
		for (i = 0; i < 5; i++) begin
			ev(15'h4000 >> i);
			rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h01 << ceb[i], "common_flag");
		end
		v = 8'($urandom);
		ev({5'b00111, v[6:0]});
		rchk(rsq_pkg::RSQ_CMD_RD_STB, {6'h00, v[6], 1'b1}, "device_summary");
		rchk(rsq_pkg::RSQ_CMD_RD_MEASURE_EVENT_FLAGS, 8'h23, "measure_flags");
		rchk(rsq_pkg::RSQ_CMD_RD_JUDGEMENT_EVENT_FLAGS, {1'b0, v[6:0]}, "judge_flags");
		rchk(rsq_pkg::RSQ_CMD_RD_MEASURE_EVENT_FLAGS, 8'h00, "measure_clear");
		cw(rsq_pkg::RSQ_CMD_WR_ESE, 8'h20);
		cw(rsq_pkg::RSQ_CMD_WR_SRE, 8'h20);
		ev(15'h2000);
		check("srq_raise", service_req, 1'b1);
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h60, "stb_summary");
		pl(2);
		check("poll", {poll_valid, poll_data[6], service_req}, 3'b110);
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h60, "mss_sticky");
		ev(15'h007F);
		cw(rsq_pkg::RSQ_CMD_CLS, 8'h00);
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h00, "cls_stb");
		rchk(rsq_pkg::RSQ_CMD_RD_JUDGEMENT_EVENT_FLAGS, 8'h00, "cls_judge");
		push_n(10);
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h10, "msg_waiting");
		stall <= 1'b0;
		repeat (80) @(posedge clk);
		check("drained", got_q.size(), 10);
		for (i = 0; i < 10; i++) check("queue_order", got_q[i], exp_q[i]);
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h00, "msg_gone");
		stall <= 1'b1;
		repeat (2) @(posedge clk);
		push_n(rsq_pkg::OQ_DEPTH + 3);
		check("overflow_flush", tx_valid, 1'b0);
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h04, "overflow_err");
		push_n(1);
		pl(0);
		repeat (2) @(posedge clk);
		#1;
		check("msg_flush", tx_valid, 1'b0);
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h04, "msg_query_err");
		pl(1);
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h04, "empty_read");
		@(posedge clk);
		in_valid <= 1'b1;
		repeat (300) @(posedge clk);
		#1;
		check("gpib_wait", in_ready, 1'b0);
		check("fill", acc >= rsq_pkg::IB_DEPTH, 1'b1);
		gpib_select <= 1'b0;
		repeat (4) @(posedge clk);
		ev(15'h0400);
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h00, "opc_serial");
		check("refused", refused > 0, 1'b1);
		@(posedge clk);
		in_valid <= 1'b0;
		rx_en <= 1'b1;
		repeat (1500) @(posedge clk);
		check("drain_count", rx_idx, acc);
		for (i = 0; i < 3; i++) begin
			w = 16'($urandom);
			pth({5'b00010, w});
			check("path_load", {path_valid, path_value}, {1'b1, w});
			pth({5'b00011, ~w});
			check("path_common", {path_valid, path_value}, {1'b1, w});
			pth({5'b10000 >> i, 16'h0000});
			check("path_clear", path_valid, 1'b0);
		end
		pth({5'b00010, w});
		push_n(1);
		ev(15'h0800);
		cw(rsq_pkg::RSQ_CMD_DCL, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		check("dcl_path", path_valid, 1'b0);
		rchk(rsq_pkg::RSQ_CMD_RD_STB, 8'h00, "dcl_mav");
		rchk(rsq_pkg::RSQ_CMD_RD_ESR, 8'h08, "dcl_keeps_flags");
		final_report();
	end
endmodule

// file: sim/rsq_ctrl_model.sv
// controller model: reads queued response bytes with random pauses
`timescale 1ns/1ps
module rsq_ctrl_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic stall,
	output logic tx_ready
);
	// ready changes only just after an edge; a stall holds it low
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= !stall && ($urandom_range(3) != 0);
		end
	end
endmodule
